// ---- dpah_dev_model.sv ----
// Purpose: Behavioural dual-port RAM device, left port on the host
// Assumes: Right port driven by bench tasks, 16K x 18 array
// Notes: Busy comes from an address match with the right port only
`timescale 1ns/1ps
`default_nettype none
module dpah_dev_model
(
  input wire logic clk_in,
  input wire dpah_pkg::dpah_pins_s pins_in,
  input wire logic [dpah_pkg::DATA_W-1:0] wr_data_in,
  output logic [dpah_pkg::DATA_W-1:0] rd_data_out,
  output logic busy_n_out,
  output logic int_n_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Shared array
  logic [dpah_pkg::DATA_W-1:0] mem [int];
  logic right_act;
  logic [dpah_pkg::ADDR_W-1:0] right_addr;
  logic int_r_n;
  logic [1:0] owner [8];
  logic [7:0] pend [3];
  dpah_pkg::dpah_pins_s prev;
  logic [dpah_pkg::DATA_W-1:0] last;
  logic [dpah_pkg::DATA_W-1:0] sem_q;
  initial
  begin
    right_act = 1'b0;
    right_addr = dpah_pkg::ADDR_ZERO;
    int_r_n = 1'b1;
    int_n_out = 1'b1;
    last = dpah_pkg::DATA_ZERO;
    sem_q = ~dpah_pkg::DATA_ZERO;
    prev = dpah_pkg::PINS_IDLE;
    foreach (owner[i]) owner[i] = 2'h0;
    foreach (pend[i]) pend[i] = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Loser sees busy
  assign busy_n_out = !(right_act && pins_in.addr == right_addr);
  task automatic array_write(input logic [13:0] a, input logic [17:0] d,
    input logic ub_n, input logic lb_n, input logic bsy_n, input logic lft);
    logic [17:0] v;
    v = mem.exists(a) ? mem[a] : dpah_pkg::DATA_ZERO;
    if (!ub_n) v[17:9] = d[17:9];
    if (!lb_n) v[8:0] = d[8:0];
    mem[a] = v;
    if (bsy_n && lft && a == dpah_pkg::MBOX_RIGHT_ADDR) int_r_n <= 1'b0;
    if (bsy_n && !lft && a == dpah_pkg::MBOX_LEFT_ADDR) int_n_out <= 1'b0;
  endtask : array_write
  task automatic sem_write(input logic lft, input logic [2:0] s,
    input logic b);
    logic [1:0] me;
    logic [1:0] oth;
    me = lft ? 2'h1 : 2'h2;
    oth = lft ? 2'h2 : 2'h1;
    if (!b && owner[s] == 2'h0) owner[s] = me;
    else if (!b && owner[s] != me) pend[me][s] = 1'b1;
    else if (b && owner[s] == me)
    begin
      owner[s] = pend[oth][s] ? oth : 2'h0;
      pend[oth][s] = 1'b0;
    end
    else if (b) pend[me][s] = 1'b0;
  endtask : sem_write
  task automatic right_write(input logic [13:0] a, input logic [17:0] d);
    array_write(a, d, 1'b0, 1'b0, 1'b1, 1'b0);
  endtask : right_write
  task automatic right_read(input logic [13:0] a, output logic [17:0] d);
    d = mem[a];
    if (a == dpah_pkg::MBOX_RIGHT_ADDR) int_r_n <= 1'b1;
  endtask : right_read
  task automatic right_sem(input logic [2:0] s, input logic b);
    sem_write(1'b0, s, b);
  endtask : right_sem
  function automatic logic right_sem_val(input logic [2:0] s);
    return owner[s] != 2'h2;
  endfunction : right_sem_val
  ////////////////////////////////////////////////////////////////////////////
  // Latched token on all lines
  always @*
    if (!pins_in.output_enable_n && !pins_in.chip_enable_n &&
        mem.exists(pins_in.addr))
      rd_data_out = mem[pins_in.addr];
    else if (!pins_in.output_enable_n && !pins_in.token_latch_select_n)
      rd_data_out = sem_q;
    else
      rd_data_out = ~last;
  always @(posedge clk_in)
  begin
    prev <= pins_in;
    if (!pins_in.output_enable_n) last <= rd_data_out;
    // Frozen while selected so a far write cannot disturb it
    if (pins_in.token_latch_select_n)
      sem_q <= {dpah_pkg::DATA_W{owner[pins_in.addr[2:0]] != 2'h1}};
    if (!prev.read_write_n && !prev.chip_enable_n &&
        (pins_in.read_write_n || pins_in.chip_enable_n))
      array_write(prev.addr, wr_data_in, prev.upper_lane_select_n,
        prev.lower_lane_select_n, busy_n_out, 1'b1);
    if (!prev.read_write_n && !prev.token_latch_select_n &&
        (pins_in.read_write_n || pins_in.token_latch_select_n))
      sem_write(1'b1, prev.addr[2:0], wr_data_in[0]);
    if (!prev.output_enable_n && !prev.chip_enable_n &&
        pins_in.output_enable_n && busy_n_out &&
        prev.addr == dpah_pkg::MBOX_LEFT_ADDR)
      int_n_out <= 1'b1;
  end
endmodule : dpah_dev_model
`default_nettype wire

// ---- dpah_host.sv ----
// Purpose: Host sequencer for one port of an asynchronous dual-port RAM
// Assumes: Pin inputs synchronous to clk_in, 16K x 18 part
// Notes: One command at a time; semaphore acquire polls without limit
//
// Overview of operation
// - Write ends on read/write or enable
// - Read waits flowthrough delay after writes
// - Array reads assert enable with output enable
// - Delay writes until busy has settled
// - Recover before readback, poll until zero
`timescale 1ns/1ps
`default_nettype none
module dpah_host
#(
  parameter bit OWN_LEFT = 1'b1
)
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic req_valid_in,
  input wire dpah_pkg::dpah_req_s req_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [dpah_pkg::DATA_W-1:0] rsp_data_out,
  output logic rsp_busy_out,
  output logic mailbox_flag_out,
  output dpah_pkg::dpah_pins_s pins_out,
  output logic [dpah_pkg::DATA_W-1:0] data_out,
  output logic data_oe_out,
  input wire logic [dpah_pkg::DATA_W-1:0] data_in,
  input wire logic busy_n_in,
  input wire logic int_n_in
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_SETTLE,
    S_STROBE,
    S_RELEASE,
    S_RECOVER
  } dpah_state_e;

  localparam logic [dpah_pkg::ADDR_W-1:0] OWN_MBOX =
    OWN_LEFT ? dpah_pkg::MBOX_LEFT_ADDR : dpah_pkg::MBOX_RIGHT_ADDR;
  localparam logic [dpah_pkg::ADDR_W-1:0] OTHER_MBOX =
    OWN_LEFT ? dpah_pkg::MBOX_RIGHT_ADDR : dpah_pkg::MBOX_LEFT_ADDR;

  dpah_state_e state;
  dpah_state_e next_state;
  dpah_pkg::dpah_req_s req;
  dpah_pkg::dpah_pins_s pins;
  dpah_pkg::dpah_pins_s next_pins;
  logic acq_read;
  logic next_acq_read;
  logic next_data_oe;
  logic tmr_load;
  logic [dpah_pkg::TMR_W-1:0] tmr_value;
  logic tmr_done;
  logic is_sem;
  logic is_write;
  logic finish;
  logic capture;
  logic [dpah_pkg::ADDR_W-1:0] eff_addr;
  logic [dpah_pkg::DATA_W-1:0] eff_wdata;

  ////////////////////////////////////////////////////////////////////////
  dpah_timer u_timer
  (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .load_in(tmr_load),
    .value_in(tmr_value),
    .done_out(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    is_sem = (req.cmd == dpah_pkg::CMD_SEM_READ) ||
             (req.cmd == dpah_pkg::CMD_SEM_WRITE) ||
             (req.cmd == dpah_pkg::CMD_SEM_ACQUIRE);
    is_write = (req.cmd == dpah_pkg::CMD_WRITE) ||
               (req.cmd == dpah_pkg::CMD_SEM_WRITE) ||
               (req.cmd == dpah_pkg::CMD_MBOX_POST) ||
               ((req.cmd == dpah_pkg::CMD_SEM_ACQUIRE) && !acq_read);
    eff_addr = req.addr;
    eff_wdata = req.wdata;
    if (req.cmd == dpah_pkg::CMD_MBOX_POST)
      eff_addr = OTHER_MBOX;
    else if (req.cmd == dpah_pkg::CMD_MBOX_READ)
      eff_addr = OWN_MBOX;
    if (is_sem)
      eff_addr = {{(dpah_pkg::ADDR_W-dpah_pkg::SEM_ADDR_W){1'b0}},
                  req.addr[dpah_pkg::SEM_ADDR_W-1:0]};
    if (req.cmd == dpah_pkg::CMD_SEM_ACQUIRE)
      eff_wdata = {{(dpah_pkg::DATA_W-1){1'b0}}, dpah_pkg::SEM_REQUEST};
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state = state;
    next_pins = pins;
    next_acq_read = acq_read;
    next_data_oe = data_oe_out;
    tmr_load = 1'b0;
    tmr_value = dpah_pkg::SETTLE_CYC;
    finish = 1'b0;
    capture = 1'b0;
    unique case (state)
      S_IDLE:
      begin
        if (req_valid_in)
        begin
          next_state = S_SETTLE;
          next_acq_read = 1'b0;
          tmr_load = 1'b1;
        end
      end
      S_SETTLE:
      begin
        next_pins.addr = eff_addr;
        next_data_oe = is_write;
        if (tmr_done && (busy_n_in || is_sem))
        begin
          next_state = S_STROBE;
          next_pins.read_write_n = !is_write;
          next_pins.output_enable_n = is_write;
          tmr_load = 1'b1;
          tmr_value = is_write ? dpah_pkg::WRITE_CYC : dpah_pkg::READ_CYC;
          if (is_sem)
          begin
            next_pins.chip_enable_n = 1'b1;
            next_pins.token_latch_select_n = 1'b0;
            next_pins.upper_lane_select_n = 1'b1;
            next_pins.lower_lane_select_n = 1'b1;
          end
          else
          begin
            next_pins.chip_enable_n = 1'b0;
            next_pins.upper_lane_select_n = req.upper_lane_n;
            next_pins.lower_lane_select_n = req.lower_lane_n;
          end
        end
      end
      S_STROBE:
      begin
        if (tmr_done)
        begin
          tmr_load = 1'b1;
          if (is_write)
          begin
            next_pins.read_write_n = 1'b1;
            next_state = S_RELEASE;
            tmr_value = dpah_pkg::RELEASE_CYC;
          end
          else
          begin
            capture = 1'b1;
            next_pins = dpah_pkg::PINS_IDLE;
            next_pins.addr = pins.addr;
            next_state = S_RECOVER;
            tmr_value = dpah_pkg::RECOVER_CYC;
          end
        end
      end
      S_RELEASE:
      begin
        if (tmr_done)
        begin
          next_pins = dpah_pkg::PINS_IDLE;
          next_pins.addr = pins.addr;
          next_data_oe = 1'b0;
          next_state = S_RECOVER;
          tmr_load = 1'b1;
          tmr_value = dpah_pkg::RECOVER_CYC;
        end
      end
      S_RECOVER:
      begin
        if (tmr_done)
        begin
          if ((req.cmd == dpah_pkg::CMD_SEM_ACQUIRE) &&
              (!acq_read || rsp_data_out[dpah_pkg::SEM_BIT]))
          begin
            next_acq_read = 1'b1;
            next_state = S_SETTLE;
            tmr_load = 1'b1;
          end
          else
          begin
            finish = 1'b1;
            next_state = S_IDLE;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state <= S_IDLE;
      acq_read <= 1'b0;
    end
    else
    begin
      state <= next_state;
      acq_read <= next_acq_read;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      req <= '0;
    else if ((state == S_IDLE) && req_valid_in)
      req <= req_in;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pins <= dpah_pkg::PINS_IDLE;
      data_oe_out <= 1'b0;
      data_out <= dpah_pkg::DATA_ZERO;
    end
    else
    begin
      pins <= next_pins;
      data_oe_out <= next_data_oe;
      data_out <= eff_wdata;
    end
  end

  // Contention seen mid-strobe means the device may have dropped the access
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rsp_busy_out <= 1'b0;
    else if ((state == S_IDLE) && req_valid_in)
      rsp_busy_out <= 1'b0;
    else if ((state == S_STROBE) && !is_sem && !busy_n_in)
      rsp_busy_out <= 1'b1;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rsp_data_out <= dpah_pkg::DATA_ZERO;
      rsp_valid_out <= 1'b0;
      mailbox_flag_out <= 1'b0;
    end
    else
    begin
      if (capture)
        rsp_data_out <= data_in;
      rsp_valid_out <= finish;
      mailbox_flag_out <= !int_n_in;
    end
  end

  assign req_ready_out = (state == S_IDLE);
  assign pins_out = pins;

  ////////////////////////////////////////////////////////////////////////
  chk_token_ce_high: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !pins.token_latch_select_n |-> pins.chip_enable_n)
    else $error("Enable low during token access");

  chk_read_enables: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !pins.output_enable_n |->
      pins.read_write_n &&
      (!pins.chip_enable_n || !pins.token_latch_select_n))
    else $error("Output enable without a select");

  chk_write_end_data: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(pins.read_write_n) |->
      data_oe_out && !(pins.chip_enable_n && pins.token_latch_select_n))
    else $error("Write ended without data or select");

  chk_busy_before_write: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ($fell(pins.chip_enable_n) && !pins.read_write_n) |-> $past(busy_n_in))
    else $error("Array write begun while busy");

  chk_read_flow_wait: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $fell(pins.output_enable_n) |-> !pins.output_enable_n [*6])
    else $error("Read strobe shorter than flowthrough");

  chk_token_recover: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(pins.token_latch_select_n) |=> pins.token_latch_select_n [*2])
    else $error("Token select recovery too short");

  chk_acquire_owned: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (rsp_valid_out && (req.cmd == dpah_pkg::CMD_SEM_ACQUIRE)) |->
      !rsp_data_out[dpah_pkg::SEM_BIT])
    else $error("Acquire finished without ownership");

  chk_lane_write: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (!pins.chip_enable_n && !pins.read_write_n) |->
      !(pins.upper_lane_select_n && pins.lower_lane_select_n))
    else $error("Array write with no lane selected");

endmodule : dpah_host
`default_nettype wire

// ---- dpah_pkg.sv ----
// Purpose: Shared constants and types for the dual-port RAM port host
// Assumes: 16K x 18 part, one port driven, 200 MHz host clock
// Notes: Pin timing figures are plain defaults, adjust per speed grade
package dpah_pkg;

  localparam int ADDR_W = 14;
  localparam int DATA_W = 18;
  localparam int SEM_ADDR_W = 3;
  localparam int SEM_BIT = 0;
  localparam int TMR_W = 8;

  localparam int CLK_PERIOD_NS = 5;
  localparam int T_BUSY_SETTLE_NS = 20;
  localparam int T_WRITE_PULSE_NS = 20;
  localparam int T_READ_FLOW_NS = 30;
  localparam int T_SEM_RECOVER_NS = 10;
  localparam int T_RELEASE_NS = 5;

  // Least times, so round up
  localparam logic [TMR_W-1:0] SETTLE_CYC =
    TMR_W'((T_BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] WRITE_CYC =
    TMR_W'((T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] READ_CYC =
    TMR_W'((T_READ_FLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] RECOVER_CYC =
    TMR_W'((T_SEM_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] RELEASE_CYC =
    TMR_W'((T_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR = 14'h3FFF;
  localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR = 14'h3FFE;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 14'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 18'h00000;
  localparam logic SEM_REQUEST = 1'b0;
  localparam logic SEM_RELEASE = 1'b1;

  typedef enum logic [2:0] {
    CMD_READ,
    CMD_WRITE,
    CMD_SEM_READ,
    CMD_SEM_WRITE,
    CMD_SEM_ACQUIRE,
    CMD_MBOX_POST,
    CMD_MBOX_READ
  } dpah_cmd_e;

  typedef struct packed {
    dpah_cmd_e cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic upper_lane_n;
    logic lower_lane_n;
  } dpah_req_s;

  typedef struct packed {
    logic chip_enable_n;
    logic read_write_n;
    logic output_enable_n;
    logic token_latch_select_n;
    logic upper_lane_select_n;
    logic lower_lane_select_n;
    logic [ADDR_W-1:0] addr;
  } dpah_pins_s;

  localparam dpah_pins_s PINS_IDLE = '{
    chip_enable_n: 1'b1,
    read_write_n: 1'b1,
    output_enable_n: 1'b1,
    token_latch_select_n: 1'b1,
    upper_lane_select_n: 1'b1,
    lower_lane_select_n: 1'b1,
    addr: ADDR_ZERO
  };

endpackage : dpah_pkg

// ---- dpah_testbench.sv ----
// Purpose: Self-checking bench for the dual-port RAM host
// Assumes: Host owns the left port, device model on the far side
// Notes: Right port acts through model tasks and right_act, between and during host accesses
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_in, resetn_in, req_valid_in, req_ready_out, rsp_valid_out;
  logic rsp_busy_out, mailbox_flag_out, data_oe_out, busy_n_in, int_n_in;
  dpah_pkg::dpah_req_s req_in;
  dpah_pkg::dpah_pins_s pins_out;
  logic [17:0] rsp_data_out, data_out, data_in, dev_data, v;
  int bad_count, checks;
  assign data_in = data_oe_out ? data_out : dev_data;
  dpah_host #(.OWN_LEFT(1'b1)) dut (.clk_in, .resetn_in, .req_valid_in,
    .req_in, .req_ready_out, .rsp_valid_out, .rsp_data_out, .rsp_busy_out,
    .mailbox_flag_out, .pins_out, .data_out, .data_oe_out, .data_in,
    .busy_n_in, .int_n_in);
  dpah_dev_model dev (.clk_in, .pins_in(pins_out), .wr_data_in(data_out),
    .rd_data_out(dev_data), .busy_n_out(busy_n_in), .int_n_out(int_n_in));
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [19:0] e,
    input logic [19:0] g);
    checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : chk
  task automatic cmd(input dpah_pkg::dpah_cmd_e c, input logic [13:0] a,
    input logic [17:0] d, input logic [1:0] ln);
    int n;
    @(negedge clk_in);
    req_in = '{c, a, d, ln[1], ln[0]};
    req_valid_in = 1'b1;
    @(negedge clk_in);
    req_valid_in = 1'b0;
    n = 0;
    while (rsp_valid_out !== 1'b1 && n < 2000)
    begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 2000) chk("rsp_valid", 20'h1, 20'h0);
  endtask : cmd
  // Right port grabs the location once the host strobe is under way
  task automatic blocked(input dpah_pkg::dpah_cmd_e c,
    input logic [13:0] a);
    fork
      cmd(c, a, 18'h00777, 2'h0);
      begin
        wait (pins_out.chip_enable_n === 1'b0);
        @(negedge clk_in);
        dev.right_addr = a;
        dev.right_act = 1'b1;
      end
    join
    chk("busy seen", 20'h1, 20'(rsp_busy_out));
    dev.right_act = 1'b0;
  endtask : blocked
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_array;
    cmd(dpah_pkg::CMD_WRITE, 14'h0123, 18'h3FFFF, 2'h0);
    cmd(dpah_pkg::CMD_WRITE, 14'h0123, 18'h00000, 2'h1);
    cmd(dpah_pkg::CMD_READ, 14'h0123, 18'h00000, 2'h0);
    chk("upper only", 20'h001FF, 20'(rsp_data_out));
    cmd(dpah_pkg::CMD_WRITE, 14'h0123, 18'h2AAAA, 2'h2);
    dev.right_read(14'h0123, v);
    chk("lower only", 20'h000AA, 20'(v));
    dev.right_write(14'h0124, 18'h15555);
    cmd(dpah_pkg::CMD_READ, 14'h0124, 18'h00000, 2'h0);
    chk("far write", 20'h15555, 20'(rsp_data_out));
  endtask : t_array
  task automatic t_mbox;
    dev.right_write(dpah_pkg::MBOX_LEFT_ADDR, 18'h1A5A5);
    repeat (3) @(negedge clk_in);
    chk("flag set", 20'h1, 20'(mailbox_flag_out));
    cmd(dpah_pkg::CMD_MBOX_READ, 14'h0000, 18'h00000, 2'h0);
    chk("own mbox", 20'h1A5A5, 20'(rsp_data_out));
    chk("flag clear", 20'h0, 20'(mailbox_flag_out));
    cmd(dpah_pkg::CMD_MBOX_POST, 14'h0000, 18'h0BEEF, 2'h0);
    chk("far flag", 20'h0, 20'(dev.int_r_n));
    cmd(dpah_pkg::CMD_READ, dpah_pkg::MBOX_RIGHT_ADDR, 18'h0, 2'h0);
    chk("peek", 20'h0BEEF, 20'(rsp_data_out));
    chk("far flag kept", 20'h0, 20'(dev.int_r_n));
    dev.right_read(dpah_pkg::MBOX_RIGHT_ADDR, v);
  endtask : t_mbox
  task automatic t_busy;
    dev.right_addr = 14'h0200;
    dev.right_act = 1'b1;
    fork
      cmd(dpah_pkg::CMD_WRITE, 14'h0200, 18'h12345, 2'h0);
      begin
        repeat (30) @(negedge clk_in);
        chk("held off", 20'h1, 20'(pins_out.chip_enable_n));
        dev.right_act = 1'b0;
      end
    join
    chk("busy clear", 20'h0, 20'(rsp_busy_out));
    dev.right_read(14'h0200, v);
    chk("late write", 20'h12345, 20'(v));
    blocked(dpah_pkg::CMD_MBOX_POST, dpah_pkg::MBOX_RIGHT_ADDR);
    chk("no far flag", 20'h1, 20'(dev.int_r_n));
    dev.right_write(dpah_pkg::MBOX_LEFT_ADDR, 18'h00042);
    blocked(dpah_pkg::CMD_MBOX_READ, dpah_pkg::MBOX_LEFT_ADDR);
    chk("flag kept", 20'h1, 20'(mailbox_flag_out));
  endtask : t_busy
  task automatic t_sem;
    cmd(dpah_pkg::CMD_SEM_ACQUIRE, 14'h3FF3, 18'h3FFFF, 2'h3);
    chk("acquired", 20'h0, 20'(rsp_data_out[0]));
    chk("far sees one", 20'h1, 20'(dev.right_sem_val(3'h3)));
    dev.right_sem(3'h3, 1'b1);
    dev.right_sem(3'h3, 1'b0);
    cmd(dpah_pkg::CMD_SEM_READ, 14'h0003, 18'h0, 2'h3);
    chk("all lines", 20'h00000, 20'(rsp_data_out));
    cmd(dpah_pkg::CMD_SEM_WRITE, 14'h0003, 18'h00001, 2'h3);
    chk("handover", 20'h0, 20'(dev.right_sem_val(3'h3)));
    cmd(dpah_pkg::CMD_SEM_WRITE, 14'h0003, 18'h3FFFE, 2'h3);
    dev.right_sem(3'h3, 1'b1);
    cmd(dpah_pkg::CMD_SEM_READ, 14'h0003, 18'h0, 2'h3);
    chk("pending won", 20'h00000, 20'(rsp_data_out));
    cmd(dpah_pkg::CMD_SEM_WRITE, 14'h0003, 18'h00001, 2'h3);
    cmd(dpah_pkg::CMD_SEM_READ, 14'h0003, 18'h0, 2'h3);
    chk("free", 20'h3FFFF, 20'(rsp_data_out));
    dev.right_sem(3'h5, 1'b0);
    fork
      cmd(dpah_pkg::CMD_SEM_ACQUIRE, 14'h0005, 18'h0, 2'h3);
      begin
        repeat (60) @(negedge clk_in);
        chk("polling", 20'h0, 20'(rsp_valid_out));
        dev.right_sem(3'h5, 1'b1);
      end
    join
    chk("polled win", 20'h0, 20'(rsp_data_out[0]));
  endtask : t_sem
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  initial
  begin
    #100000;
    bad_count++;
    complete_run();
  end
  initial
  begin
    resetn_in = 1'b0;
    req_valid_in = 1'b0;
    req_in = '0;
    bad_count = 0;
    checks = 0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    resetn_in = 1'b1;
    chk("idle pins", 20'(dpah_pkg::PINS_IDLE), 20'(pins_out));
    chk("idle ready", 20'h1, 20'(req_ready_out));
    t_array();
    t_mbox();
    t_busy();
    t_sem();
    complete_run();
  end
endmodule : testbench
`default_nettype wire

// ---- dpah_timer.sv ----
// Purpose: Down counter that times each pin phase
// Assumes: Load value of at least one cycle
// Notes: Done is high once the loaded count has run out
`timescale 1ns/1ps
`default_nettype none
module dpah_timer
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic load_in,
  input wire logic [dpah_pkg::TMR_W-1:0] value_in,
  output logic done_out
);

  logic [dpah_pkg::TMR_W-1:0] count;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      count <= '0;
    else if (load_in)
      count <= value_in;
    else if (count != '0)
      count <= count - 1'b1;
  end

  assign done_out = (count == '0);

endmodule : dpah_timer
`default_nettype wire
